// File: core/pixel_color_pkg.sv
// shared constants and types for the pixel colour processing path
// Operation
// - software reads live first-tap low byte
// - software reads live shifter lane A byte
// - software reads live memory-write lane A byte
// - channel-keep code passes all or one colour
// - source bit picks acquisition or display shift
// - four-bit display shift amount, bits 30..27
// - direction bit: zero right, one left
// - each channel times gain, over 64, clamped
// - output selector picks rgb, raw, intensity, single
// - depth field selects 8, 12, 10 bits
// - phase field sets first two mosaic colours
// - gain register layout is firmware-variant specific
package pixel_color_pkg;
  // register byte offsets
  localparam logic [3:0] DIAG_SHIFT_ADDR   = 4'h0;
  localparam logic [3:0] GAIN_DECODER_ADDR = 4'h4;
  // diagnostic and display shift field positions
  localparam int TAP_LSB      = 0;
  localparam int SHIFTER_LSB  = 8;
  localparam int MEM_LSB      = 16;
  localparam int KEEP_LSB     = 24;
  localparam int SRC_SEL_BIT  = 26;
  localparam int AMT_LSB      = 27;
  localparam int LEFT_BIT     = 31;
  // reset values: display control clear, unity gains
  localparam logic [7:0]  VIEW_CTRL_RESET = 8'h00;
  localparam logic [31:0] GAIN_CTRL_RESET = 32'h00404040;
  // gain scaling and saturation
  localparam int         GAIN_SHIFT = 6;
  localparam logic [7:0] SAT_MAX    = 8'hff;
  // line buffer length
  localparam int LINE_PIXELS = 2048;
  localparam int COL_W       = 11;
  // channel-keep codes
  localparam logic [1:0] KEEP_ALL   = 2'h0;
  localparam logic [1:0] KEEP_RED   = 2'h1;
  localparam logic [1:0] KEEP_GREEN = 2'h2;
  localparam logic [1:0] KEEP_BLUE  = 2'h3;
  // decoder output codes
  localparam logic [2:0] OUT_RGB   = 3'h0;
  localparam logic [2:0] OUT_RAW   = 3'h1;
  localparam logic [2:0] OUT_INTEN = 3'h2;
  localparam logic [2:0] OUT_RED   = 3'h3;
  localparam logic [2:0] OUT_GREEN = 3'h4;
  localparam logic [2:0] OUT_BLUE  = 3'h5;
  // pixel depth codes
  localparam logic [1:0] DEPTH_8  = 2'h0;
  localparam logic [1:0] DEPTH_12 = 2'h1;
  localparam logic [1:0] DEPTH_10 = 2'h2;
  // one colour pixel
  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } rgb_t;
  // writable upper byte of the diagnostic register
  typedef struct packed {
    logic       left;
    logic [3:0] amount;
    logic       src_sel;
    logic [1:0] keep;
  } view_ctrl_t;
  // gain and decoder control register
  typedef struct packed {
    logic [1:0] phase;
    logic [1:0] depth;
    logic       rsvd;
    logic [2:0] outsel;
    logic [7:0] blue;
    logic [7:0] green;
    logic [7:0] red;
  } gain_ctrl_t;
endpackage : pixel_color_pkg

// File: core/pixel_color_processing.sv
// pixel colour processing path with avalon register slave
//
// Chosen here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
module pixel_color_processing
  import pixel_color_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // avalon-mm register slave
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // camera first tap
  input  wire logic        tap_valid,
  input  wire logic        tap_sof,
  input  wire logic        tap_sol,
  input  wire logic [11:0] tap_data,
  // acquisition shift code
  input  wire logic [3:0]  acq_shift_amount,
  input  wire logic        acq_shift_left,
  // frame memory lanes
  output logic             mem_valid,
  output rgb_t             mem_pixel
);

  // register state
  view_ctrl_t view_reg;                  // display shift and keep
  gain_ctrl_t gain_reg;                  // gains and decoder setup
  logic       ack_reg;                   // answer cycle of a request
  logic [7:0] first_tap_live_value;      // latest tap low byte
  logic [7:0] shifter_output_live_sample; // lane A shifter byte
  logic [7:0] memory_write_live_sample;  // lane A memory byte

  // pipeline state
  logic             v1_reg;              // stage one valid
  logic [7:0]       cur_reg;             // current normalised pixel
  logic [7:0]       left_reg;            // pixel to the left
  logic [7:0]       up_reg;              // pixel above
  logic [7:0]       ul_reg;              // pixel above-left
  logic             row_reg;             // row parity of current
  logic             colp_reg;            // column parity of current
  logic [COL_W-1:0] col_reg;             // column counter
  logic             rowcnt_reg;          // running row parity
  logic [7:0]       line_mem [LINE_PIXELS]; // previous row
  logic             v2_reg;              // stage two valid
  rgb_t             proc_reg;            // gained and masked pixel

  // combinational intermediates
  logic             req;
  logic [COL_W-1:0] col_next;
  logic             row_next;
  logic [7:0]       norm;
  rgb_t             dec;
  rgb_t             sel;
  rgb_t             gained;
  rgb_t             kept;
  rgb_t             shifted;
  logic [3:0]       sh_amt;
  logic             sh_left;

  // scale one channel by its gain, truncate, then saturate
  function automatic logic [7:0] apply_gain(input logic [7:0] v, input logic [7:0] g);
    logic [15:0] prod;
    logic [9:0]  scaled;
    prod   = v * g;
    scaled = prod[GAIN_SHIFT +: 10];
    apply_gain = (scaled > 10'(SAT_MAX)) ? SAT_MAX : scaled[7:0];
  endfunction : apply_gain

  // barrel shift one lane
  function automatic logic [7:0] bshift(input logic [7:0] v, input logic [3:0] n,
                                        input logic l);
    bshift = l ? 8'(v << n) : 8'(v >> n);
  endfunction : bshift

  // average of two bytes
  function automatic logic [7:0] avg2(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    avg2 = s[8:1];
  endfunction : avg2

  // bus handshake: one wait cycle, then the answer
  assign req         = read | write;
  assign waitrequest = req & ~ack_reg;

  // answer strobe toggles on for one cycle per request
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  // read data captured in the wait cycle, side-effect free
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      readdata <= 32'h0;
    end else if (read && !ack_reg) begin
      case (address)
        DIAG_SHIFT_ADDR: begin
          readdata <= {view_reg,
                       memory_write_live_sample,
                       shifter_output_live_sample,
                       first_tap_live_value};
        end
        GAIN_DECODER_ADDR: begin
          readdata <= gain_reg;
        end
        default: begin
          readdata <= 32'h0;                         // unmapped reads zero
        end
      endcase
    end
  end

  // display control: only the top byte is writable
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      view_reg <= VIEW_CTRL_RESET;
    end else if (write && ack_reg && address == DIAG_SHIFT_ADDR && byteenable[3]) begin
      view_reg <= writedata[31:24];
    end
  end

  // gain and decoder control, per byte lane
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gain_reg <= GAIN_CTRL_RESET;
    end else if (write && ack_reg && address == GAIN_DECODER_ADDR) begin
      for (int i = 0; i < 4; i++) begin
        if (byteenable[i]) begin
          gain_reg[i*8 +: 8] <= writedata[i*8 +: 8];
        end
      end
    end
  end

  // normalise tap depth to a byte
  always_comb begin
    case (gain_reg.depth)
      DEPTH_12: norm = tap_data[11:4];
      DEPTH_10: norm = tap_data[9:2];
      default:  norm = tap_data[7:0];
    endcase
  end

  // column and row position of the arriving pixel
  assign col_next = tap_sol ? '0 : COL_W'(col_reg + 1'b1);
  assign row_next = tap_sof ? 1'b0 : (tap_sol ? ~rowcnt_reg : rowcnt_reg);

  // position counters
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      col_reg    <= '0;
      rowcnt_reg <= 1'b0;
    end else if (tap_valid) begin
      col_reg    <= col_next;
      rowcnt_reg <= row_next;
    end
  end

  // previous-row buffer, read before overwrite
  always_ff @(posedge clk) begin
    if (tap_valid) begin
      line_mem[col_next] <= norm;
    end
  end

  // stage one: 2x2 mosaic window
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      v1_reg   <= 1'b0;
      cur_reg  <= 8'h00;
      left_reg <= 8'h00;
      up_reg   <= 8'h00;
      ul_reg   <= 8'h00;
      row_reg  <= 1'b0;
      colp_reg <= 1'b0;
    end else begin
      v1_reg <= tap_valid;
      if (tap_valid) begin
        cur_reg  <= norm;
        left_reg <= cur_reg;
        up_reg   <= line_mem[col_next];
        ul_reg   <= up_reg;
        row_reg  <= row_next;
        colp_reg <= col_next[0];
      end
    end
  end

  // live low byte of the first tap
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      first_tap_live_value <= 8'h00;
    end else begin
      first_tap_live_value <= tap_data[7:0];
    end
  end

  // mosaic decode from the phase and position
  always_comb begin
    logic green_here;
    logic row_red;
    logic [7:0] same_c;
    logic [7:0] other_c;
    same_c     = 8'h00;                                    // set on both branches below
    other_c    = 8'h00;                                    // set on both branches below
    green_here = colp_reg ^ row_reg ^ gain_reg.phase[0];
    row_red    = row_reg ^ gain_reg.phase[1];
    if (green_here) begin
      dec.g   = avg2(cur_reg, ul_reg);
      same_c  = left_reg;
      other_c = up_reg;
    end else begin
      dec.g   = avg2(left_reg, up_reg);
      same_c  = cur_reg;
      other_c = ul_reg;
    end
    dec.r = row_red ? same_c : other_c;
    dec.b = row_red ? other_c : same_c;
  end

  // decoder output selection
  always_comb begin
    logic [9:0] inten;
    inten = {2'b00, dec.r} + {1'b0, dec.g, 1'b0} + {2'b00, dec.b};
    case (gain_reg.outsel)
      OUT_RGB:   sel = dec;
      OUT_RAW:   sel = '{cur_reg, cur_reg, cur_reg};
      OUT_INTEN: sel = '{inten[9:2], inten[9:2], inten[9:2]};
      OUT_RED:   sel = '{dec.r, dec.r, dec.r};
      OUT_GREEN: sel = '{dec.g, dec.g, dec.g};
      OUT_BLUE:  sel = '{dec.b, dec.b, dec.b};
      default:   sel = dec;                                // reserved codes
    endcase
  end

  // per-channel gain, then channel keep
  always_comb begin
    gained.r = apply_gain(sel.r, gain_reg.red);
    gained.g = apply_gain(sel.g, gain_reg.green);
    gained.b = apply_gain(sel.b, gain_reg.blue);
    kept     = gained;
    case (view_reg.keep)
      KEEP_RED:   kept = '{gained.r, 8'h00, 8'h00};
      KEEP_GREEN: kept = '{8'h00, gained.g, 8'h00};
      KEEP_BLUE:  kept = '{8'h00, 8'h00, gained.b};
      default:    kept = gained;
    endcase
  end

  // stage two: processed pixel
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      v2_reg   <= 1'b0;
      proc_reg <= '0;
    end else begin
      v2_reg <= v1_reg;
      if (v1_reg) begin
        proc_reg <= kept;
      end
    end
  end

  // shift code source and barrel shift of each lane
  assign sh_amt  = view_reg.src_sel ? view_reg.amount : acq_shift_amount;
  assign sh_left = view_reg.src_sel ? view_reg.left : acq_shift_left;
  assign shifted = '{bshift(proc_reg.r, sh_amt, sh_left),
                     bshift(proc_reg.g, sh_amt, sh_left),
                     bshift(proc_reg.b, sh_amt, sh_left)};

  // stage three: frame memory write
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_valid <= 1'b0;
      mem_pixel <= '0;
    end else begin
      mem_valid <= v2_reg;
      if (v2_reg) begin
        mem_pixel <= shifted;
      end
    end
  end

  // live lane A taps of shifter and memory write
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      shifter_output_live_sample <= 8'h00;
      memory_write_live_sample   <= 8'h00;
    end else begin
      shifter_output_live_sample <= shifted.r;
      memory_write_live_sample   <= mem_pixel.r;
    end
  end

endmodule : pixel_color_processing

// File: test/pixel_color_assertions.sv
// checker for register bus timing and pixel pipeline timing
`timescale 1ns/1ps
module pixel_color_assertions
  import pixel_color_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // register bus
  input wire logic [3:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  // pixel ends
  input wire logic        tap_valid,
  input wire logic [11:0] tap_data,
  input wire logic        mem_valid,
  input wire rgb_t        mem_pixel
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // a request still waiting for its answer
  sequence req_wait_s;
    (read || write) && waitrequest;
  endsequence
  // a read being captured
  sequence rd_take_s;
    read && waitrequest;
  endsequence
  one_wait_a: assert property (req_wait_s |=> !waitrequest)
    else $error("request waited more than one cycle");
  wait_cause_a: assert property (waitrequest |-> (read || write))
    else $error("wait without request");
  first_wait_a: assert property ($rose(read || write) |-> waitrequest)
    else $error("no wait in first request cycle");
  tap_diag_a: assert property (rd_take_s ##0 (address == 4'h0 && $stable(tap_data))
    |=> readdata[7:0] == $past(tap_data[7:0])) else $error("tap byte wrong");
  rd_unmapped_a: assert property (rd_take_s ##0 (address != 4'h0 && address != 4'h4)
    |=> readdata == 32'h0) else $error("unmapped read not zero");
  rd_hold_a: assert property (!(read && waitrequest) |=> $stable(readdata))
    else $error("read data moved");
  pix_lat_a: assert property (tap_valid |-> ##3 mem_valid)
    else $error("pixel late or lost");
  pix_idle_a: assert property (!tap_valid |-> ##3 !mem_valid)
    else $error("spurious pixel");
  pix_hold_a: assert property ($changed(mem_pixel) |-> mem_valid)
    else $error("pixel changed without valid");
endmodule : pixel_color_assertions

bind pixel_color_processing pixel_color_assertions i_pixel_color_assertions (
  .clk(clk), .rst_b(rst_b), .address(address), .read(read), .write(write),
  .readdata(readdata), .waitrequest(waitrequest), .tap_valid(tap_valid),
  .tap_data(tap_data), .mem_valid(mem_valid), .mem_pixel(mem_pixel));

// File: test/camera_tap_model.sv
// camera model driving the first tap
`timescale 1ns/1ps
module camera_tap_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // bench commands
  input  wire logic        send,
  input  wire logic        new_line,
  input  wire logic        new_frame,
  input  wire logic [11:0] value,
  // first tap
  output logic             tap_valid,
  output logic             tap_sof,
  output logic             tap_sol,
  output logic [11:0]      tap_data
);
  logic [11:0] last; // last pixel sent
  // one pixel per clock while send is high; idle lines show the inverse
  // of the last pixel so stale data never passes for fresh
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tap_valid <= 1'b0;
      tap_sof   <= 1'b0;
      tap_sol   <= 1'b0;
      tap_data  <= 12'h000;
      last      <= 12'h000;
    end else begin
      tap_valid <= send;
      tap_sof   <= send & new_frame;
      tap_sol   <= send & (new_frame | new_line);
      tap_data  <= send ? value : ~last;
      if (send) begin
        last <= value;
      end
    end
  end
endmodule : camera_tap_model

// File: test/pixel_color_processing_test.sv
// self-checking bench for the pixel colour processing path
`timescale 1ns/1ps
module pixel_color_processing_test;
  import pixel_color_pkg::*;
  // clock, reset and register bus
  logic        clk, rst_b, read, write, waitrequest;
  logic [3:0]  address, byteenable;
  logic [31:0] writedata, readdata, q;
  // camera side and acquisition shift code
  logic        tap_valid, tap_sof, tap_sol, send, new_line, new_frame;
  logic [11:0] tap_data, value;
  logic [3:0]  acq_shift_amount;
  logic        acq_shift_left, mem_valid;
  rgb_t        mem_pixel;
  int          mismatches, comparisons;
  pixel_color_processing i_pixel_color_processing (.clk(clk), .rst_b(rst_b),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .tap_valid(tap_valid), .tap_sof(tap_sof), .tap_sol(tap_sol), .tap_data(tap_data),
    .acq_shift_amount(acq_shift_amount), .acq_shift_left(acq_shift_left),
    .mem_valid(mem_valid), .mem_pixel(mem_pixel));
  camera_tap_model i_camera_tap_model (.clk(clk), .rst_b(rst_b), .send(send),
    .new_line(new_line), .new_frame(new_frame), .value(value), .tap_valid(tap_valid),
    .tap_sof(tap_sof), .tap_sol(tap_sol), .tap_data(tap_data));
  // 250 MHz clock
  always #2 clk = ~clk;
  // compare one result word
  task automatic chk(input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // compare the held output pixel
  task automatic chkpx(input logic [23:0] e);
    chk({8'h0, mem_pixel}, {8'h0, e});
  endtask : chkpx
  // one avalon transfer, held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] r);
    @(posedge clk);
    address <= a; write <= wr; read <= !wr; writedata <= d; byteenable <= be;
    do @(posedge clk); while (waitrequest !== 1'b0);
    r = readdata;
    read <= 1'b0; write <= 1'b0;
  endtask : bus
  // gain stage: scale by gain over 64, clamp at 255
  function automatic logic [7:0] gn(input logic [7:0] v, g);
    logic [15:0] p;
    p = (16'(v) * 16'(g)) >> 6;
    return (p > 16'h00ff) ? 8'hff : p[7:0];
  endfunction : gn
  // two lines of four pixels, a b a b then c d c d, then let the pipeline drain
  task automatic mosaic(input logic [11:0] a, b, c, d);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      send <= 1'b1; new_frame <= (i == 0); new_line <= (i == 4);
      value <= (i < 4) ? (i[0] ? b : a) : (i[0] ? d : c);
    end
    @(posedge clk);
    send <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : mosaic
  // flat image of one value
  task automatic frame(input logic [11:0] v);
    mosaic(v, v, v, v);
  endtask : frame
  // reset values, unmapped access and byte lanes
  task automatic t_reset;
    bus(1'b0, 4'h4, 32'h0, 4'hf, q); chk(q, GAIN_CTRL_RESET);
    bus(1'b0, 4'h0, 32'h0, 4'hf, q); chk(q[31:24], VIEW_CTRL_RESET);
    bus(1'b1, 4'h8, 32'hffffffff, 4'hf, q);
    bus(1'b0, 4'h8, 32'h0, 4'hf, q); chk(q, 32'h0);
    bus(1'b1, 4'h4, 32'h11223344, 4'h1, q);
    bus(1'b0, 4'h4, 32'h0, 4'hf, q); chk(q, 32'h00404044);
  endtask : t_reset
  // every depth code in raw mode
  task automatic t_depth;
    logic [7:0] e [4] = '{8'hbc, 8'hab, 8'haf, 8'hbc};
    for (int d = 0; d < 4; d++) begin
      bus(1'b1, 4'h4, {4'(d), 1'b0, OUT_RAW, 24'h404040}, 4'hf, q);
      frame(12'habc);
      chkpx({3{e[d]}});
    end
  endtask : t_depth
  // every output code in every phase on a mosaic with red 40, green 20, blue 10;
  // the last window holds one red, one blue and two greens, so the decode is exact
  task automatic t_modes;
    logic [11:0] pa [4] = '{12'h010, 12'h020, 12'h040, 12'h020};
    logic [11:0] pb [4] = '{12'h020, 12'h010, 12'h020, 12'h040};
    logic [11:0] pc [4] = '{12'h020, 12'h040, 12'h020, 12'h010};
    logic [11:0] pd [4] = '{12'h040, 12'h020, 12'h010, 12'h020};
    logic [7:0]  er, eg, eb;
    for (int o = 0; o < 8; o++) begin
      for (int p = 0; p < 4; p++) begin
        bus(1'b1, 4'h4, {2'(p), 3'h0, 3'(o), 24'hff2080}, 4'hf, q);
        mosaic(pa[p], pb[p], pc[p], pd[p]);
        // raw is the last pixel, intensity (40 + 2*20 + 10) / 4
        case (o)
          1:       {er, eg, eb} = {3{pd[p][7:0]}};
          2:       {er, eg, eb} = {3{8'h24}};
          3:       {er, eg, eb} = {3{8'h40}};
          4:       {er, eg, eb} = {3{8'h20}};
          5:       {er, eg, eb} = {3{8'h10}};
          default: {er, eg, eb} = 24'h402010;
        endcase
        chkpx({gn(er, 8'h80), gn(eg, 8'h20), gn(eb, 8'hff)});
      end
    end
  endtask : t_modes
  // every channel-keep code
  task automatic t_keep;
    logic [23:0] m [4] = '{24'hffffff, 24'hff0000, 24'h00ff00, 24'h0000ff};
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, 4'h0, {6'h0, 2'(k), 24'h0}, 4'h8, q);
      frame(12'h0c0);
      chkpx(m[k] & {gn(8'hc0, 8'h80), gn(8'hc0, 8'h20), gn(8'hc0, 8'hff)});
    end
  endtask : t_keep
  // shift source, amount and direction, then the diagnostic taps
  task automatic t_shift;
    logic [7:0] vb [4] = '{8'hfc, 8'h00, 8'h1c, 8'h9c};
    logic [7:0] e [4] = '{8'h00, 8'h68, 8'h0b, 8'hd0};
    // acquisition code left by two, seen only while the source bit is clear
    acq_shift_amount <= 4'h2;
    acq_shift_left   <= 1'b1;
    bus(1'b1, 4'h4, {8'h00, 24'h404040}, 4'hf, q);
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 4'h0, {vb[i], 24'h0}, 4'h8, q);
      frame(12'h05a);
      chkpx({3{e[i]}});
    end
    bus(1'b1, 4'h0, 32'hffffffff, 4'h7, q);
    bus(1'b0, 4'h0, 32'h0, 4'hf, q);
    chk(q, 32'h9cd0d0a5);
  endtask : t_shift
  // print counts and verdict, then stop
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  // watchdog far beyond the expected run
  initial begin
    #40000;
    mismatches++;
    results;
  end
  // main sequence
  initial begin
    clk = 1'b0; rst_b = 1'b0; read = 1'b0; write = 1'b0; address = 4'h0;
    writedata = 32'h0; byteenable = 4'h0; send = 1'b0; new_line = 1'b0;
    new_frame = 1'b0; value = 12'h000; acq_shift_amount = 4'h0; acq_shift_left = 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    t_reset;
    t_depth;
    t_modes;
    t_keep;
    t_shift;
    results;
  end
endmodule : pixel_color_processing_test
